// ==== sere_read_engine.sv ====
// read-side two-wire slave engine with the address pointer
`timescale 1ns/1ps
`default_nettype none
module sere_read_engine
    import sere_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        scl_pin,
    input  wire logic        sda_in,
    output var  logic        sda_out,
    output var  logic        sda_oe,
    input  wire logic        chip_select_bit_zero,
    input  wire logic        chip_select_bit_one,
    input  wire logic        chip_select_bit_two,
    input  wire logic        write_busy,
    output var  logic [15:0] mem_addr,
    input  wire logic [7:0]  mem_rdata
);

    // ========================================================
    // pin synchronisers
    logic       scl_meta_reg;
    logic       scl_s_reg;
    logic       scl_d_reg;
    logic       sda_meta_reg;
    logic       sda_s_reg;
    logic       sda_d_reg;
    logic [2:0] cs_meta_reg;
    logic [2:0] cs_s_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            scl_meta_reg <= 1'b1;
            scl_s_reg    <= 1'b1;
            scl_d_reg    <= 1'b1;
            sda_meta_reg <= 1'b1;
            sda_s_reg    <= 1'b1;
            sda_d_reg    <= 1'b1;
            cs_meta_reg  <= 3'h0;
            cs_s_reg     <= 3'h0;
        end else begin
            scl_meta_reg <= scl_pin;
            scl_s_reg    <= scl_meta_reg;
            scl_d_reg    <= scl_s_reg;
            sda_meta_reg <= sda_in;
            sda_s_reg    <= sda_meta_reg;
            sda_d_reg    <= sda_s_reg;
            cs_meta_reg  <= {chip_select_bit_two, chip_select_bit_one, chip_select_bit_zero};
            cs_s_reg     <= cs_meta_reg;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    assign scl_rise  = scl_s_reg & ~scl_d_reg;
    assign scl_fall  = ~scl_s_reg & scl_d_reg;
    assign start_det = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
    assign stop_det  = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;

    function automatic logic [15:0] sere_inc(input logic [15:0] p);
        sere_inc = p + SERE_PTR_STEP;
    endfunction : sere_inc

    // ========================================================
    // protocol engine
    sere_state_t state_reg;
    sere_state_t state_next;
    logic [3:0]  bit_cnt_reg;
    logic [3:0]  bit_cnt_next;
    logic [7:0]  shift_reg;
    logic [7:0]  shift_next;
    logic [7:0]  addr_hi_reg;
    logic [7:0]  addr_hi_next;
    logic [15:0] ptr_reg;
    logic [15:0] ptr_next;
    logic        sda_oe_reg;
    logic        sda_oe_next;
    logic        rd_dir_reg;
    logic        rd_dir_next;
    logic        rd_owed_reg;
    logic        rd_owed_next;
    logic        ctrl_match;

    assign ctrl_match = (shift_reg[7:SERE_TYPE_POS] == SERE_DEV_TYPE)
                      && (shift_reg[SERE_TYPE_POS-1:SERE_CS_POS] == cs_s_reg);

    always_comb begin
        state_next   = state_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next   = shift_reg;
        addr_hi_next = addr_hi_reg;
        ptr_next     = ptr_reg;
        sda_oe_next  = sda_oe_reg;
        rd_dir_next  = rd_dir_reg;
        rd_owed_next = rd_owed_reg;
        if (start_det) begin
            // a repeated start ends a write but leaves the pointer as loaded
            state_next   = SERE_CTRL;
            bit_cnt_next = 4'h0;
            sda_oe_next  = 1'b0;
        end else if (stop_det) begin
            state_next   = SERE_IDLE;
            sda_oe_next  = 1'b0;
            rd_owed_next = 1'b0;
            if (rd_owed_reg) begin
                ptr_next = sere_inc(ptr_reg);
            end
        end else begin
            case (state_reg)
                SERE_CTRL, SERE_ADDR_HI, SERE_ADDR_LO: begin
                    if (scl_rise) begin
                        shift_next   = {shift_reg[6:0], sda_s_reg};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == SERE_BITS_BYTE) begin
                        bit_cnt_next = 4'h0;
                        if (state_reg == SERE_CTRL) begin
                            if (ctrl_match && !write_busy) begin
                                sda_oe_next = 1'b1;
                                rd_dir_next = shift_reg[SERE_DIR_POS];
                                state_next  = SERE_CTRL_ACK;
                            end else begin
                                state_next = SERE_IGNORE;
                            end
                        end else if (state_reg == SERE_ADDR_HI) begin
                            addr_hi_next = shift_reg;
                            sda_oe_next  = 1'b1;
                            state_next   = SERE_AH_ACK;
                        end else begin
                            ptr_next    = {addr_hi_reg, shift_reg};
                            sda_oe_next = 1'b1;
                            state_next  = SERE_AL_ACK;
                        end
                    end
                end
                SERE_CTRL_ACK: begin
                    if (scl_fall) begin
                        if (rd_dir_reg) begin
                            // byte at the pointer goes out msb first
                            shift_next   = mem_rdata;
                            sda_oe_next  = ~mem_rdata[7];
                            bit_cnt_next = 4'h0;
                            rd_owed_next = 1'b1;
                            state_next   = SERE_RD_BYTE;
                        end else begin
                            sda_oe_next = 1'b0;
                            state_next  = SERE_ADDR_HI;
                        end
                    end
                end
                SERE_AH_ACK: begin
                    if (scl_fall) begin
                        sda_oe_next = 1'b0;
                        state_next  = SERE_ADDR_LO;
                    end
                end
                SERE_AL_ACK: begin
                    // data bytes of a write belong to the write engine
                    if (scl_fall) begin
                        sda_oe_next = 1'b0;
                        state_next  = SERE_IGNORE;
                    end
                end
                SERE_RD_BYTE: begin
                    if (scl_fall) begin
                        if (bit_cnt_reg == SERE_LAST_TX_BIT) begin
                            sda_oe_next  = 1'b0;
                            bit_cnt_next = 4'h0;
                            state_next   = SERE_RD_ACK;
                        end else begin
                            shift_next   = {shift_reg[6:0], 1'b0};
                            sda_oe_next  = ~shift_reg[6];
                            bit_cnt_next = bit_cnt_reg + 4'h1;
                        end
                    end
                end
                SERE_RD_ACK: begin
                    if (scl_rise) begin
                        if (!sda_s_reg) begin
                            // master ack: step on and reuse the ack path to send again
                            ptr_next     = sere_inc(ptr_reg);
                            rd_owed_next = 1'b0;
                            rd_dir_next  = 1'b1;
                            state_next   = SERE_CTRL_ACK;
                        end else begin
                            state_next = SERE_IGNORE;
                        end
                    end
                end
                SERE_IDLE, SERE_IGNORE: begin
                    state_next = state_reg;
                end
                default: begin
                    state_next  = SERE_IDLE;
                    sda_oe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_reg   <= SERE_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 8'h00;
            addr_hi_reg <= 8'h00;
            ptr_reg     <= SERE_PTR_RST;
            sda_oe_reg  <= 1'b0;
            rd_dir_reg  <= 1'b0;
            rd_owed_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg   <= shift_next;
            addr_hi_reg <= addr_hi_next;
            ptr_reg     <= ptr_next;
            sda_oe_reg  <= sda_oe_next;
            rd_dir_reg  <= rd_dir_next;
            rd_owed_reg <= rd_owed_next;
        end
    end

    // open drain: the line is only ever pulled low
    assign sda_out  = 1'b0;
    assign sda_oe   = sda_oe_reg;
    assign mem_addr = ptr_reg;

    // ========================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence ctrl_done_s;
        state_reg == SERE_CTRL && scl_fall && bit_cnt_reg == SERE_BITS_BYTE;
    endsequence
    sequence master_ack_s;
        state_reg == SERE_RD_ACK && scl_rise && !sda_s_reg && !start_det && !stop_det;
    endsequence

    drive_states_a: assert property (sda_oe_reg |-> state_reg inside {SERE_CTRL_ACK, SERE_AH_ACK,
        SERE_AL_ACK, SERE_RD_BYTE}) else $error("sda driven outside ack or data");
    busy_noack_a: assert property (ctrl_done_s and (write_busy && !start_det && !stop_det)
        |=> state_reg == SERE_IGNORE && !sda_oe_reg) else $error("control acked while busy");
    ctrl_ack_a: assert property (ctrl_done_s and (ctrl_match && !write_busy && !start_det && !stop_det)
        |=> sda_oe_reg && state_reg == SERE_CTRL_ACK) else $error("matching control not acked");
    first_bit_a: assert property (state_reg == SERE_CTRL_ACK && rd_dir_reg && scl_fall && !start_det
        && !stop_det |=> state_reg == SERE_RD_BYTE && sda_oe_reg == !$past(mem_rdata[7]))
        else $error("first data bit wrong");
    ack_inc_a: assert property (master_ack_s |=> ptr_reg == $past(ptr_reg) + 16'h0001
        && state_reg == SERE_CTRL_ACK) else $error("ack did not advance pointer");
    roll_over_a: assert property (master_ack_s and (ptr_reg == 16'hffff) |=> ptr_reg == 16'h0000)
        else $error("pointer did not roll over");
    stop_inc_a: assert property (stop_det && rd_owed_reg |=> ptr_reg == $past(ptr_reg) + 16'h0001
        ##1 !rd_owed_reg) else $error("stop did not advance pointer");
    addr_load_a: assert property (state_reg == SERE_ADDR_LO && scl_fall && bit_cnt_reg == SERE_BITS_BYTE
        && !start_det && !stop_det |=> ptr_reg == {$past(addr_hi_reg), $past(shift_reg)})
        else $error("address not loaded");
    restart_keep_a: assert property (start_det |=> $stable(ptr_reg) && state_reg == SERE_CTRL)
        else $error("start disturbed pointer");

endmodule : sere_read_engine
`default_nettype wire

// ==== sere_pkg.sv ====
// constants and types of the serial eeprom read engine
// Functional notes
// - reads start like writes, direction bit one
// - current, random and sequential reads supported
// - pointer holds last accessed location plus one
// - pointer rolls over to zero past top
// - acknowledge read control byte, shift out byte
// - master nacks and stops; device releases data
// - repeated start after address keeps pointer value
// - read control byte acked, loaded byte returned
// - after random read pointer follows read byte
// - master ack requests next consecutive byte
// - pointer increments on master ack and stop
// - control byte: type code, selects, direction
// - no control acknowledge during write cycle
`default_nettype none
package sere_pkg;

    // ========================================================
    // sizes, counts and reset values
    localparam int          SERE_ADDR_W      = 16;
    localparam int          SERE_DATA_W      = 8;
    localparam logic [3:0]  SERE_BITS_BYTE   = 4'h8;
    localparam logic [3:0]  SERE_LAST_TX_BIT = 4'h7;
    localparam logic [15:0] SERE_PTR_RST     = 16'h0000;
    localparam logic [15:0] SERE_PTR_STEP    = 16'h0001;
    // device type nibble: value is arbitrary
    localparam logic [3:0]  SERE_DEV_TYPE    = 4'h5;
    localparam int          SERE_TYPE_POS    = 4;
    localparam int          SERE_CS_POS      = 1;
    localparam int          SERE_DIR_POS     = 0;

    // ========================================================
    // link states
    typedef enum logic [3:0] {
        SERE_IDLE,
        SERE_CTRL,
        SERE_CTRL_ACK,
        SERE_ADDR_HI,
        SERE_AH_ACK,
        SERE_ADDR_LO,
        SERE_AL_ACK,
        SERE_RD_BYTE,
        SERE_RD_ACK,
        SERE_IGNORE
    } sere_state_t;

endpackage : sere_pkg
`default_nettype wire

// ==== sere_master_model.sv ====
// two-wire bus master model driving scl and the master side of sda
`timescale 1ns/1ps
`default_nettype none
module sere_master_model (
    input  wire logic core_clk,
    input  wire logic sda_in,
    output var  logic scl_pin,
    output var  logic sda_drv
);
    // ============================================================
    // idle bus: both lines released, scl stands still between frames
    initial begin
        scl_pin = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge core_clk);
    endtask : wait_clk

    // ============================================================
    // start, also used as repeated start from mid-frame
    task automatic start_cond();
        wait_clk(3);
        sda_drv = 1'b1;
        wait_clk(3);
        scl_pin = 1'b1;
        wait_clk(6);
        sda_drv = 1'b0;
        wait_clk(6);
        scl_pin = 1'b0;
    endtask : start_cond

    // stop after the last byte
    task automatic stop_cond();
        wait_clk(3);
        sda_drv = 1'b0;
        wait_clk(3);
        scl_pin = 1'b1;
        wait_clk(6);
        sda_drv = 1'b1;
        wait_clk(6);
    endtask : stop_cond

    // data moves mid-low so the synchronised scl edge never races it
    task automatic bit_cycle(input logic tx, output logic rx);
        wait_clk(3);
        sda_drv = tx;
        wait_clk(3);
        scl_pin = 1'b1;
        wait_clk(6);
        rx = sda_in;
        scl_pin = 1'b0;
    endtask : bit_cycle

    // msb first, ninth bit is the acknowledge slot
    task automatic xfer_byte(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx, output logic ack_rx);
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(tx[i], rx[i]);
        end
        bit_cycle(ack_tx, ack_rx);
    endtask : xfer_byte
endmodule : sere_master_model
`default_nettype wire

// ==== sere_read_engine_tb_top.sv ====
// self-checking bench for the read engine against a bus master model
`timescale 1ns/1ps
`default_nettype none
module sere_read_engine_tb_top
    import sere_pkg::*;
;
    `define SERE_CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end

    logic        core_clk;
    logic        rst_b;
    logic        write_busy;
    logic [2:0]  cs_strap;
    logic [7:0]  mem_rdata;
    logic [15:0] mem_addr;
    logic        sda_out;
    logic        sda_oe;
    logic        scl_pin;
    logic        sda_drv;
    wire         sda_in = sda_drv & ~(sda_oe & ~sda_out);
    int          mismatches = 0;
    int          checks_done = 0;

    // ============================================================
    // instances
    sere_read_engine dut_u (.core_clk(core_clk), .rst_b(rst_b), .scl_pin(scl_pin), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_bit_zero(cs_strap[0]),
        .chip_select_bit_one(cs_strap[1]), .chip_select_bit_two(cs_strap[2]),
        .write_busy(write_busy), .mem_addr(mem_addr), .mem_rdata(mem_rdata));
    sere_master_model master_u (.core_clk(core_clk), .sda_in(sda_in), .scl_pin(scl_pin), .sda_drv(sda_drv));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // array contents: an address pattern; 16'hffff and the wrapped 16'h0000 both read 8'h5a
    function automatic logic [7:0] array_byte(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction : array_byte

    always @(negedge core_clk) begin
        mem_rdata <= array_byte(mem_addr);
    end

    // ============================================================
    // bus sequences
    task automatic ctrl_byte(input logic dir, input logic exp_ack);
        logic [7:0] rx;
        logic       ack;
        master_u.xfer_byte({SERE_DEV_TYPE, cs_strap, dir}, 1'b1, rx, ack);
        `SERE_CHK(ack, exp_ack)
    endtask : ctrl_byte

    task automatic set_ptr(input logic [15:0] a);
        logic [7:0] rx;
        logic       ack;
        master_u.start_cond();
        ctrl_byte(1'b0, 1'b0);
        master_u.xfer_byte(a[15:8], 1'b1, rx, ack);
        `SERE_CHK(ack, 1'b0)
        master_u.xfer_byte(a[7:0], 1'b1, rx, ack);
        `SERE_CHK(ack, 1'b0)
    endtask : set_ptr

    task automatic read_bytes(input int n, input logic [15:0] first);
        logic [7:0]  rx;
        logic        ack;
        logic [15:0] a;
        a = first;
        master_u.start_cond();
        ctrl_byte(1'b1, 1'b0);
        for (int k = 0; k < n; k++) begin
            master_u.xfer_byte(8'hff, (k == n - 1), rx, ack);
            `SERE_CHK(rx, array_byte(a))
            a = a + SERE_PTR_STEP;
        end
        master_u.stop_cond();
        repeat (8) @(negedge core_clk);
        `SERE_CHK(mem_addr, a)
        `SERE_CHK(sda_oe, 1'b0)
    endtask : read_bytes

    // ============================================================
    // scenarios
    task automatic sc_reset();
        `SERE_CHK(mem_addr, SERE_PTR_RST)
        `SERE_CHK(sda_oe, 1'b0)
        `SERE_CHK(sda_out, 1'b0)
    endtask : sc_reset

    task automatic sc_random_then_current();
        // the pointer is set once by a dummy write, then the second, current read trusts it
        set_ptr(16'h1234);
        read_bytes(1, 16'h1234);
        read_bytes(1, 16'h1235);
    endtask : sc_random_then_current

    task automatic sc_sequential_wrap();
        set_ptr(16'hfffe);
        read_bytes(3, 16'hfffe);
    endtask : sc_sequential_wrap

    task automatic sc_refused();
        logic [7:0] rx;
        logic       ack;
        master_u.start_cond();
        master_u.xfer_byte({SERE_DEV_TYPE, ~cs_strap, 1'b1}, 1'b1, rx, ack);
        `SERE_CHK(ack, 1'b1)
        master_u.stop_cond();
        master_u.start_cond();
        master_u.xfer_byte({~SERE_DEV_TYPE, cs_strap, 1'b1}, 1'b1, rx, ack);
        `SERE_CHK(ack, 1'b1)
        master_u.stop_cond();
        write_busy = 1'b1;
        master_u.start_cond();
        ctrl_byte(1'b1, 1'b1);
        master_u.stop_cond();
        write_busy = 1'b0;
        // pointer unchanged and device answers again once the write cycle ends
        read_bytes(1, 16'h0001);
    endtask : sc_refused

    task automatic end_of_test();
        if (mismatches == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    // ============================================================
    // main sequence
    initial begin
        rst_b = 1'b0;
        write_busy = 1'b0;
        cs_strap = 3'h5;
        repeat (12) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (6) @(negedge core_clk);
        sc_reset();
        sc_random_then_current();
        sc_sequential_wrap();
        sc_refused();
        end_of_test();
    end
endmodule : sere_read_engine_tb_top
`default_nettype wire
